// ===== rtl/oaf_encoder.sv
// Frame encoder: header build, payload pad/invert, mapping, spreading, blocks
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module oaf_encoder import oaf_pkg::*; #(
    parameter logic [`OAF_LFSR_W-1:0] LFSR_TAPS = 15'h6000,
    parameter logic [63:0] TRAIN_SEQ = 64'h0
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mac_valid,
    input wire logic mac_bit,
    input wire logic mac_last,
    output logic mac_ready,
    output logic rs_in_valid,
    output logic rs_in_bit,
    output logic rs_in_hdr,
    output logic rs_in_last,
    input wire logic rs_in_ready,
    input wire logic rs_out_valid,
    input wire logic rs_out_bit,
    input wire logic rs_out_last,
    output logic rs_out_ready,
    output logic sym_valid,
    output oaf_sym_s sym,
    input wire logic sym_ready
);

// ***************************************************************
// Reset release
// ***************************************************************
logic rst_meta_q;
logic rst_n_q;

always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        rst_meta_q <= 1'b0;
        rst_n_q <= 1'b0;
    end else begin
        rst_meta_q <= 1'b1;
        rst_n_q <= rst_meta_q;
    end
end

// ***************************************************************
// Helpers
// ***************************************************************
function automatic logic [`OAF_HDR_W-1:0] hdr_word(input oaf_st_s s);
    logic [`OAF_HDR_W-1:0] h;
    h = '0;
    h[`OAF_H_SEED +: 2] = s.seed;
    h[`OAF_H_INV] = s.inv;
    h[`OAF_H_TFP] = `OAF_FLAG_ZERO;
    h[`OAF_H_PL +: 2] = `OAF_PL_ZERO;
    h[`OAF_H_RPL +: 2] = `OAF_PL_ZERO;
    h[`OAF_H_SEG +: 4] = s.has_pay ? `OAF_SEG_PAY : `OAF_SEG_NONE;
    h[`OAF_H_SUC +: 6] = s.has_pay ? `OAF_SUC_PAY : `OAF_SUC_NONE;
    h[`OAF_H_MODE +: 2] = s.mode;
    h[`OAF_H_LEN +: 16] = s.len;
    h[`OAF_H_MID] = `OAF_FLAG_ZERO;
    h[`OAF_H_SEGMENT_CONTINUES] = `OAF_FLAG_ZERO;
    // Training field flag stays zero, though four-level mode appends a training field to frames with payload
    return h;
endfunction

// Gray pair, earlier bit first
function automatic logic [1:0] gray(input logic b0, input logic b1);
    return {b0, b0 ^ b1};
endfunction

function automatic logic [1:0] pilot_lvl(input logic [1:0] m, input logic [2:0] i);
    logic [7:0] four;
    four = `OAF_PILOT_FOUR;
    unique case (m)
        `OAF_MODE_FAST: pilot_lvl = {1'b0, 1'(`OAF_PILOT_FAST >> i[1:0])};
        `OAF_MODE_FOUR: pilot_lvl = four[{i[1:0], 1'b0} +: 2];
        default: pilot_lvl = {1'b0, 1'(`OAF_PILOT_BASE >> i)};
    endcase
endfunction

// ***************************************************************
// State
// ***************************************************************
oaf_st_s q;
oaf_st_s d;
logic [`OAF_HDR_W-1:0] hdr;
logic [1:0] eff_mode;
logic eff_four;
logic sf_two;
logic [9:0] nd_last;
logic [2:0] np_last;
logic [1:0] rep_n;
logic scr_bit;
logic [`OAF_LFSR_W-1:0] lfsr_nx;
logic [10:0] icnt_nx;

// Header always uses base geometry
assign eff_mode = (q.oph == O_HDR) ? `OAF_MODE_BASE : q.mode;
assign eff_four = (eff_mode == `OAF_MODE_FOUR);
assign sf_two = (eff_mode == `OAF_MODE_BASE);
assign nd_last = sf_two ? `OAF_ND_LAST_SF2 : `OAF_ND_LAST_SF1;
assign np_last = sf_two ? `OAF_NP_LAST_SF2 : `OAF_NP_LAST_SF1;
assign rep_n = sf_two ? `OAF_REP_SF2 : `OAF_REP_SF1;
assign hdr = hdr_word(q);
// Stand-in whitening sequence; polynomial set by parameter
assign scr_bit = ^(q.lfsr & LFSR_TAPS);
assign lfsr_nx = {q.lfsr[`OAF_LFSR_W-2:0], scr_bit};
assign icnt_nx = (q.icnt == `OAF_PAD_LAST) ? 11'h0 : q.icnt + 11'h1;

always_comb begin
    logic start_req;
    logic g;
    start_req = 1'b0;
    g = 1'b0;
    d = q;

    // ***********************************************************
    // AXI4-Lite slave
    // ***********************************************************
    if (s_axi_awvalid && q.awready) begin
        d.aw_held = 1'b1;
        d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
        d.w_held = 1'b1;
        d.wdata = s_axi_wdata;
        d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
        d.bvalid = 1'b0;
    end
    if (q.aw_held && q.w_held && !q.bvalid) begin
        d.aw_held = 1'b0;
        d.w_held = 1'b0;
        d.bvalid = 1'b1;
        d.bresp = `OAF_RESP_OKAY;
        case ({q.awaddr[3:2], 2'b00})
            `OAF_OFF_CTRL: begin
                // Config frozen while a frame is in flight
                if (!q.busy && q.wstrb[0]) begin
                    d.mode = q.wdata[`OAF_CTRL_MODE +: 2];
                    if (d.mode == `OAF_MODE_BAD) begin
                        d.mode = `OAF_MODE_BASE;
                    end
                    d.has_pay = q.wdata[`OAF_CTRL_PAY];
                    d.retx = q.wdata[`OAF_CTRL_RETX +: 4];
                    start_req = q.wdata[`OAF_CTRL_START];
                end
            end
            `OAF_OFF_LEN: begin
                if (!q.busy && q.wstrb[0]) begin
                    d.len[7:0] = q.wdata[7:0];
                end
                if (!q.busy && q.wstrb[1]) begin
                    d.len[15:8] = q.wdata[15:8];
                end
            end
            `OAF_OFF_STAT: begin
            end
            default: begin
                d.bresp = `OAF_RESP_SLVERR;
            end
        endcase
    end
    if (q.rvalid && s_axi_rready) begin
        d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
        d.rvalid = 1'b1;
        d.rresp = `OAF_RESP_OKAY;
        case ({s_axi_araddr[3:2], 2'b00})
            `OAF_OFF_CTRL: d.rdata = {24'h0, q.retx, q.has_pay, q.mode, 1'b0};
            `OAF_OFF_LEN: d.rdata = {16'h0, q.len};
            `OAF_OFF_STAT: d.rdata = {q.frames, 8'h0, q.retx, q.seed, q.inv, q.busy};
            default: begin
                d.rdata = 32'h0;
                d.rresp = `OAF_RESP_SLVERR;
            end
        endcase
    end
    d.awready = !d.aw_held && !d.bvalid;
    d.wready = !d.w_held && !d.bvalid;
    d.arready = !d.rvalid;

    // ***********************************************************
    // Frame start
    // ***********************************************************
    if (start_req) begin
        d.busy = 1'b1;
        d.inv = d.retx[0];
        // Even index (first send included) draws a new seed; odd keeps it
        if (!d.retx[0]) begin
            d.seed = q.seed_ctr;
            d.seed_ctr = q.seed_ctr + 2'h1;
        end
        d.frames = q.frames + 16'h1;
        d.iph = I_HDR;
        d.icnt = 11'h0;
        d.lfsr = {d.seed, `OAF_LFSR_FILL};
        d.oph = O_HDR;
        d.dcnt = 10'h0;
        d.pidx = 3'h0;
        d.pilot_on = 1'b0;
        d.pad_on = 1'b0;
        d.fin = 1'b0;
        d.rep = 2'h0;
        d.half_have = 1'b0;
        d.tidx = 5'h0;
    end

    // ***********************************************************
    // Scramble and pad toward the RS coder
    // ***********************************************************
    if (q.rs_in_valid && rs_in_ready) begin
        d.rs_in_valid = 1'b0;
    end
    unique case (q.iph)
        I_IDLE: begin
        end
        I_HDR: begin
            if (!q.rs_in_valid || rs_in_ready) begin
                d.rs_in_valid = 1'b1;
                d.rs_in_bit = hdr[q.icnt[5:0]] ^ scr_bit;
                d.rs_in_hdr = 1'b1;
                d.rs_in_last = (q.icnt[5:0] == `OAF_HDR_LAST);
                d.lfsr = lfsr_nx;
                d.icnt = q.icnt + 11'h1;
                if (d.rs_in_last) begin
                    d.icnt = 11'h0;
                    d.lfsr = {q.seed, `OAF_LFSR_FILL};
                    d.iph = q.has_pay ? I_PAY : I_IDLE;
                end
            end
        end
        I_PAY: begin
            // Ready is only raised with the output slot empty
            if (mac_valid && q.mac_ready) begin
                d.rs_in_valid = 1'b1;
                d.rs_in_bit = mac_bit ^ scr_bit;
                d.rs_in_hdr = 1'b0;
                d.lfsr = lfsr_nx;
                d.icnt = icnt_nx;
                d.rs_in_last = mac_last && (q.icnt == `OAF_PAD_LAST);
                if (mac_last) begin
                    d.iph = d.rs_in_last ? I_IDLE : I_PAD;
                end
            end
        end
        I_PAD: begin
            if (!q.rs_in_valid || rs_in_ready) begin
                d.rs_in_valid = 1'b1;
                d.rs_in_bit = 1'b0;
                d.rs_in_hdr = 1'b0;
                d.rs_in_last = (q.icnt == `OAF_PAD_LAST);
                d.icnt = icnt_nx;
                if (d.rs_in_last) begin
                    d.iph = I_IDLE;
                end
            end
        end
    endcase
    // Half rate on the MAC side, traded for a registered ready
    d.mac_ready = (d.iph == I_PAY) && !d.rs_in_valid;

    // ***********************************************************
    // Symbol emission: pilots, zero pad, spread data
    // ***********************************************************
    if (q.sym_valid && sym_ready) begin
        d.sym_valid = 1'b0;
    end
    if (!q.sym_valid || sym_ready) begin
        if (q.pilot_on) begin
            d.sym_valid = 1'b1;
            d.sym.level = pilot_lvl(eff_mode, q.pidx);
            d.sym.pilot = 1'b1;
            d.sym.hdr = (q.oph == O_HDR);
            d.pidx = q.pidx + 3'h1;
            if (q.pidx == np_last) begin
                d.pilot_on = 1'b0;
                d.pidx = 3'h0;
            end
        end else if (q.pad_on || q.rep != 2'h0) begin
            d.sym_valid = 1'b1;
            d.sym.level = q.pad_on ? 2'h0 : q.cur_lvl;
            d.sym.pilot = 1'b0;
            d.sym.hdr = (q.oph == O_HDR);
            if (!q.pad_on) begin
                d.rep = q.rep - 2'h1;
            end
            d.dcnt = q.dcnt + 10'h1;
            if (q.dcnt == nd_last) begin
                d.dcnt = 10'h0;
                d.pilot_on = 1'b1;
                d.pad_on = 1'b0;
            end
        end
    end

    // ***********************************************************
    // Coded bit intake, inversion and mapping
    // ***********************************************************
    if (rs_out_valid && q.rs_out_ready) begin
        g = rs_out_bit ^ (q.inv && q.oph == O_PAY);
        if (eff_four && !q.half_have) begin
            d.half_have = 1'b1;
            d.half_bit = g;
        end else begin
            d.cur_lvl = eff_four ? gray(q.half_bit, g) : {1'b0, g};
            d.rep = rep_n;
            d.half_have = 1'b0;
        end
        if (rs_out_last) begin
            d.fin = 1'b1;
        end
    end
    if (q.oph == O_TRAIN && q.rep == 2'h0 && !q.pilot_on && !q.pad_on) begin
        d.cur_lvl = TRAIN_SEQ[{q.tidx, 1'b0} +: 2];
        d.rep = `OAF_REP_SF2;
        d.tidx = q.tidx + 5'h1;
        if (q.tidx == `OAF_TRAIN_LAST) begin
            d.tidx = 5'h0;
            d.oph = O_PAY;
        end
    end
    if ((q.oph == O_HDR || q.oph == O_PAY) && d.fin && d.rep == 2'h0
        && !d.pilot_on && !d.pad_on) begin
        if (d.half_have) begin
            // Lone trailing bit pairs with zero
            d.cur_lvl = gray(d.half_bit, 1'b0);
            d.rep = rep_n;
            d.half_have = 1'b0;
        end else if (d.dcnt != 10'h0) begin
            d.pad_on = 1'b1;
        end else begin
            d.fin = 1'b0;
            if (q.oph == O_HDR && q.has_pay) begin
                d.oph = (q.mode == `OAF_MODE_FOUR) ? O_TRAIN : O_PAY;
            end else begin
                d.oph = O_IDLE;
                d.busy = 1'b0;
            end
        end
    end
    d.rs_out_ready = (d.oph == O_HDR || d.oph == O_PAY) && !d.fin
        && d.rep == 2'h0 && !d.pilot_on && !d.pad_on;
end

always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
        q <= '0;
    end else begin
        q <= d;
    end
end

// ***************************************************************
// Outputs
// ***************************************************************
// Levels are integer indices; scaling is approximated downstream
assign s_axi_awready = q.awready;
assign s_axi_wready = q.wready;
assign s_axi_bresp = q.bresp;
assign s_axi_bvalid = q.bvalid;
assign s_axi_arready = q.arready;
assign s_axi_rdata = q.rdata;
assign s_axi_rresp = q.rresp;
assign s_axi_rvalid = q.rvalid;
assign mac_ready = q.mac_ready;
assign rs_in_valid = q.rs_in_valid;
assign rs_in_bit = q.rs_in_bit;
assign rs_in_hdr = q.rs_in_hdr;
assign rs_in_last = q.rs_in_last;
assign rs_out_ready = q.rs_out_ready;
assign sym_valid = q.sym_valid;
assign sym = q.sym;

endmodule

// ===== rtl/oaf_defines.svh
// Constants of the on-off/four-level frame encoder
`ifndef OAF_DEFINES_SVH
`define OAF_DEFINES_SVH
`define OAF_OFF_CTRL 4'h0
`define OAF_OFF_LEN 4'h4
`define OAF_OFF_STAT 4'h8
`define OAF_CTRL_START 0
`define OAF_CTRL_MODE 1
`define OAF_CTRL_PAY 3
`define OAF_CTRL_RETX 4
`define OAF_RESP_OKAY 2'h0
`define OAF_RESP_SLVERR 2'h2
`define OAF_MODE_BASE 2'h0
`define OAF_MODE_FAST 2'h1
`define OAF_MODE_FOUR 2'h2
`define OAF_MODE_BAD 2'h3
`define OAF_PAD_LAST 11'h6ff
`define OAF_ND_LAST_SF1 10'h1fb
`define OAF_ND_LAST_SF2 10'h3f7
`define OAF_NP_LAST_SF1 3'h3
`define OAF_NP_LAST_SF2 3'h7
`define OAF_REP_SF1 2'h1
`define OAF_REP_SF2 2'h2
`define OAF_TRAIN_LAST 5'h1f
`define OAF_PILOT_BASE 8'h33
`define OAF_PILOT_FAST 4'h5
`define OAF_PILOT_FOUR 8'h33
`define OAF_LFSR_W 15
`define OAF_LFSR_FILL 13'h1fff
`define OAF_HDR_W 40
`define OAF_HDR_LAST 6'h27
`define OAF_H_SEED 0
`define OAF_H_INV 2
`define OAF_H_TFP 3
`define OAF_H_PL 4
`define OAF_H_RPL 6
`define OAF_H_SEG 8
`define OAF_H_SUC 12
`define OAF_H_MODE 18
`define OAF_H_LEN 20
`define OAF_H_MID 36
`define OAF_H_SEGMENT_CONTINUES 37
`define OAF_FLAG_ZERO 1'h0
`define OAF_PL_ZERO 2'h0
`define OAF_SEG_PAY 4'h1
`define OAF_SEG_NONE 4'h0
`define OAF_SUC_PAY 6'h01
`define OAF_SUC_NONE 6'h00
`endif

// ===== rtl/oaf_pkg.sv
// Types of the on-off/four-level frame encoder
package oaf_pkg;
`include "oaf_defines.svh"

typedef enum logic [1:0] {I_IDLE, I_HDR, I_PAY, I_PAD} oaf_in_e;
typedef enum logic [1:0] {O_IDLE, O_HDR, O_TRAIN, O_PAY} oaf_out_e;

typedef struct packed {
    logic [1:0] level;
    logic pilot;
    logic hdr;
} oaf_sym_s;

typedef struct packed {
    logic awready; logic wready; logic aw_held; logic w_held;
    logic [3:0] awaddr; logic [31:0] wdata; logic [3:0] wstrb;
    logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [1:0] rresp; logic [31:0] rdata;
    logic [1:0] mode; logic has_pay; logic [3:0] retx; logic [15:0] len;
    logic busy; logic [1:0] seed; logic [1:0] seed_ctr; logic inv;
    logic [15:0] frames;
    oaf_in_e iph; logic [10:0] icnt; logic [`OAF_LFSR_W-1:0] lfsr;
    logic rs_in_valid; logic rs_in_bit; logic rs_in_hdr; logic rs_in_last;
    logic mac_ready;
    oaf_out_e oph; logic rs_out_ready; logic [1:0] cur_lvl; logic [1:0] rep;
    logic half_have; logic half_bit; logic [9:0] dcnt; logic [2:0] pidx;
    logic pilot_on; logic pad_on; logic fin; logic [4:0] tidx;
    logic sym_valid; oaf_sym_s sym;
} oaf_st_s;
endpackage

// ===== dv/oaf_encoder_props.sv
// Port checker for the frame encoder
`timescale 1ns/1ps
module oaf_encoder_props import oaf_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mac_valid,
    input wire logic mac_ready,
    input wire logic rs_in_valid,
    input wire logic rs_in_bit,
    input wire logic rs_in_hdr,
    input wire logic rs_in_last,
    input wire logic rs_in_ready,
    input wire logic sym_valid,
    input wire oaf_sym_s sym,
    input wire logic sym_ready
);
default clocking cb @(posedge core_clk);
endclocking
default disable iff (!rst_b);
property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
endproperty
a_b_hold: assert property (p_b_hold) else $error("write response dropped");
property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
endproperty
a_r_hold: assert property (p_r_hold) else $error("read data dropped");
property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
endproperty
a_r_ans: assert property (p_r_ans) else $error("read answer late");
property p_w_take;
    s_axi_wvalid && s_axi_wready |=> !s_axi_wready [*2];
endproperty
a_w_take: assert property (p_w_take) else $error("second write taken early");
property p_rs_hold;
    rs_in_valid && !rs_in_ready |=> rs_in_valid && $stable({rs_in_bit, rs_in_hdr, rs_in_last});
endproperty
a_rs_hold: assert property (p_rs_hold) else $error("coder input dropped");
property p_sym_hold;
    sym_valid && !sym_ready |=> sym_valid && $stable(sym);
endproperty
a_sym_hold: assert property (p_sym_hold) else $error("symbol dropped");
property p_mac_gap;
    mac_valid && mac_ready |=> !mac_ready;
endproperty
a_mac_gap: assert property (p_mac_gap) else $error("mac bits too close");
property p_slot;
    mac_ready |-> !rs_in_valid;
endproperty
a_slot: assert property (p_slot) else $error("mac ready with full slot");
property p_hdr_onoff;
    sym_valid && sym.hdr |-> !sym.level[1];
endproperty
a_hdr_onoff: assert property (p_hdr_onoff) else $error("header not on-off");
property p_hdr_end;
    rs_in_valid && rs_in_ready && rs_in_hdr && rs_in_last |=> !(rs_in_valid && rs_in_hdr) [*8];
endproperty
a_hdr_end: assert property (p_hdr_end) else $error("header bits after last");
endmodule

bind oaf_encoder oaf_encoder_props oaf_encoder_props_inst (.core_clk, .rst_b, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .mac_valid, .mac_ready, .rs_in_valid,
    .rs_in_bit, .rs_in_hdr, .rs_in_last, .rs_in_ready, .sym_valid, .sym, .sym_ready);

// ===== dv/oaf_far_model.sv
// Far side stand-in: MAC bit source and a pass-through coder slot
`timescale 1ns/1ps
module oaf_far_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic go,
    input wire logic [10:0] nbits,
    input wire logic slow,
    output logic mac_valid,
    output logic mac_bit,
    output logic mac_last,
    input wire logic mac_ready,
    input wire logic rs_in_valid,
    input wire logic rs_in_bit,
    input wire logic rs_in_last,
    output logic rs_in_ready,
    output logic rs_out_valid,
    output logic rs_out_bit,
    output logic rs_out_last,
    input wire logic rs_out_ready
);
logic [10:0] left_q;
logic full_q, bit_q, last_q, tg_q;
always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        left_q <= 11'h0;
        full_q <= 1'b0;
        bit_q <= 1'b0;
        last_q <= 1'b0;
        tg_q <= 1'b0;
    end else begin
        tg_q <= ~tg_q;
        if (go)
            left_q <= nbits;
        else if (mac_valid && mac_ready)
            left_q <= left_q - 11'h1;
        if (rs_in_valid && rs_in_ready) begin
            full_q <= 1'b1;
            bit_q <= rs_in_bit;
            last_q <= rs_in_last;
        end else if (rs_out_valid && rs_out_ready)
            full_q <= 1'b0;
    end
end
// Held until taken; idle bit toggles so nothing stale looks valid
assign mac_valid = left_q != 11'h0;
assign mac_bit = mac_valid ? left_q[0] ^ left_q[2] : tg_q;
assign mac_last = mac_valid && left_q == 11'h1;
// Slow mode accepts only every other cycle
assign rs_in_ready = !full_q && (!slow || tg_q);
assign rs_out_valid = full_q;
assign rs_out_bit = full_q ? bit_q : ~bit_q;
assign rs_out_last = full_q && last_q;
endmodule

// ===== dv/onoff_ask_frame_encoder_tb.sv
// Self-checking bench of the frame encoder
`timescale 1ns/1ps
`include "oaf_defines.svh"
module onoff_ask_frame_encoder_tb import oaf_pkg::*;;
logic core_clk = 0, rst_b = 0, go = 0, slow = 0, sym_ready = 0;
logic [10:0] nbits = 0;
logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
logic [31:0] s_axi_wdata = 0, s_axi_rdata;
logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
logic s_axi_rvalid, mac_valid, mac_bit, mac_last, mac_ready, rs_in_valid, rs_in_bit;
logic rs_in_hdr, rs_in_last, rs_in_ready, rs_out_valid, rs_out_bit, rs_out_last;
logic rs_out_ready, sym_valid;
logic [1:0] s_axi_bresp, s_axi_rresp, e_mode, pm;
oaf_sym_s sym;
int num_errors = 0, checked = 0, cyc = 0, hi, pay, macn, dcnt, pidx, nsym;
logic [39:0] hraw;
logic [1:0] q[$], hq[$];
logic e_inv, hb, half, v;
// Uneven training pattern so a misplaced symbol shows
localparam logic [63:0] TSEQ = 64'h1b4e_c936_27d8_e14b;
oaf_encoder #(.LFSR_TAPS(15'h6000), .TRAIN_SEQ(TSEQ)) oaf_encoder_inst (.core_clk, .rst_b,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mac_valid,
    .mac_bit, .mac_last, .mac_ready, .rs_in_valid, .rs_in_bit, .rs_in_hdr, .rs_in_last,
    .rs_in_ready, .rs_out_valid, .rs_out_bit, .rs_out_last, .rs_out_ready, .sym_valid, .sym,
    .sym_ready);
oaf_far_model oaf_far_model_inst (.core_clk, .rst_b, .go, .nbits, .slow, .mac_valid, .mac_bit,
    .mac_last, .mac_ready, .rs_in_valid, .rs_in_bit, .rs_in_last, .rs_in_ready, .rs_out_valid,
    .rs_out_bit, .rs_out_last, .rs_out_ready);
always #4 core_clk = ~core_clk;
// ****************************************
// Tasks
// ****************************************
task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    checked++;
    if (g !== e) begin
        num_errors++;
        $display("mismatch %s expected %h seen %h", n, e, g);
    end
endtask
task automatic complete_run;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
        @(posedge core_clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid !== 1'b0 || s_axi_wvalid !== 1'b0);
    s_axi_bready <= 1'b1;
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
endtask
task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
endtask
task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axr(`OAF_OFF_STAT, d, r);
    chk("status reset", 40'h0, {8'h0, d});
    axw(4'hc, 32'h1, r);
    chk("unmapped write", 40'(`OAF_RESP_SLVERR), 40'(r));
    axr(4'hc, d, r);
    chk("unmapped read", {6'h0, `OAF_RESP_SLVERR, 32'h0}, {6'h0, r, d});
    $display("register test done");
endtask
task automatic run_frame(input logic [1:0] m, input logic hp, input logic [3:0] rx,
    input logic [15:0] ln, input logic [10:0] nb, input logic [1:0] sd);
    int d, nd;
    logic [31:0] st;
    logic [1:0] r;
    logic [39:0] h;
    logic [14:0] l;
    logic b;
    e_mode = m;
    e_inv = rx[0];
    hi = 0;
    pay = 0;
    macn = 0;
    nsym = 0;
    half = 0;
    q.delete();
    hq.delete();
    nbits <= nb;
    go <= hp;
    slow <= m[0];
    @(posedge core_clk);
    go <= 1'b0;
    axw(`OAF_OFF_LEN, {16'h0, ln}, r);
    axw(`OAF_OFF_CTRL, {24'h0, rx, hp, m, 1'b1}, r);
    // Busy refuses this, so the header must keep the first length
    axw(`OAF_OFF_LEN, 32'h5a5a, r);
    axr(`OAF_OFF_STAT, st, r);
    chk("busy", 40'h1, 40'(st[0]));
    chk("status inv", 40'(rx[0]), 40'(st[1]));
    do axr(`OAF_OFF_STAT, st, r); while (st[0] === 1'b1);
    repeat (4) @(posedge core_clk);
    l = {sd, 13'h1fff};
    for (int i = 0; i < 40; i++) begin
        b = ^(l & 15'h6000);
        h[i] = hraw[i] ^ b;
        l = {l[13:0], b};
    end
    chk("header bits", 40'd40, 40'(hi));
    chk("header", {4'h0, ln, m, hp ? 6'h01 : 6'h00, hp ? 4'h1 : 4'h0, 4'h0, 1'b0, rx[0], sd},
        h);
    d = !hp ? 0 : m == 2'h0 ? 3584 : m == 2'h1 ? 1792 : 960;
    nd = m == 2'h0 ? 1016 : 508;
    chk("payload symbols", 40'((d + nd - 1) / nd * (nd + nd / 127)), 40'(nsym));
    chk("coded bits", hp ? 40'd1792 : 40'd0, 40'(pay));
    chk("levels left", 40'h0, 40'(q.size()));
    $display("frame mode %0d retx %0d done", m, rx);
endtask
task automatic t_after;
    logic [31:0] d;
    logic [1:0] r;
    axr(`OAF_OFF_CTRL, d, r);
    chk("ctrl readback", 40'h40, {8'h0, d});
    axr(`OAF_OFF_STAT, d, r);
    chk("status end", 40'h0000040048, {8'h0, d});
    // Mode code 3 is folded to base mode
    axw(`OAF_OFF_CTRL, 32'h46, r);
    axr(`OAF_OFF_CTRL, d, r);
    chk("mode fold", 40'h40, {8'h0, d});
    $display("status test done");
endtask
// ****************************************
// Monitors and timeout
// ****************************************
always @(posedge core_clk) begin
    cyc <= cyc + 1;
    sym_ready <= cyc[1:0] != 2'h0;
    if (cyc == 60000) begin
        num_errors++;
        complete_run();
    end
end
always @(posedge core_clk) if (rst_b) begin
    if (mac_valid && mac_ready) macn++;
    if (rs_in_valid && rs_in_ready && rs_in_hdr) begin
        hraw[hi] = rs_in_bit;
        hi++;
        repeat (2) hq.push_back({1'b0, rs_in_bit});
    end else if (rs_in_valid && rs_in_ready) begin
        if (pay >= macn) chk("pad bit", 40'h0, 40'(rs_in_bit));
        if (e_mode == 2'h2 && pay == 0)
            for (int n = 0; n < 64; n++) q.push_back(TSEQ[n / 2 * 2 +: 2]);
        pay++;
        v = rs_in_bit ^ e_inv;
        if (e_mode == 2'h2) begin
            if (half) q.push_back({hb, hb ^ v});
            hb = v;
            half = !half;
        end else
            repeat (e_mode == 2'h0 ? 2 : 1) q.push_back({1'b0, v});
    end
    if (sym_valid && sym_ready) begin
        if (sym.pilot) begin
            pm = sym.hdr ? 2'h0 : e_mode;
            if (pidx == 0)
                chk("block data", sym.hdr || e_mode == 2'h0 ? 40'd1016 : 40'd508, 40'(dcnt));
            chk("pilot", pm == 2'h0 ? {1'b0, ~pidx[1]} : pm == 2'h1 ? {1'b0, ~pidx[0]} :
                pidx[0] ? 2'h0 : 2'h3, 40'(sym.level));
            pidx++;
            dcnt = 0;
        end else begin
            pidx = 0;
            dcnt++;
        end
        if (!sym.hdr) nsym++;
        if (!sym.hdr && !sym.pilot)
            chk("level", q.size() > 0 ? q.pop_front() : 2'h0, 40'(sym.level));
        if (sym.hdr && !sym.pilot)
            chk("header level", hq.size() > 0 ? hq.pop_front() : 2'h0, 40'(sym.level));
    end
end
initial begin
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    do @(posedge core_clk); while (s_axi_awready !== 1'b1);
    t_regs();
    run_frame(2'h0, 1'b1, 4'h0, 16'h1234, 11'd1792, 2'h0);
    run_frame(2'h1, 1'b1, 4'h1, 16'hbeef, 11'd5, 2'h0);
    run_frame(2'h2, 1'b1, 4'h2, 16'h0f0f, 11'd1791, 2'h1);
    run_frame(2'h0, 1'b0, 4'h4, 16'h00c3, 11'd0, 2'h2);
    t_after();
    complete_run();
end
endmodule
